//--- hw/isc_status_collector.sv
module isc_status_collector
(
  input  wire logic                           ref_clk,
  input  wire logic                           resetn,
  input  wire logic                           hostWrEn,
  input  wire logic                           hostRdEn,
  input  wire logic [isc_pkg::ADDR_W-1:0]     hostAddr,
  input  wire logic [isc_pkg::DATA_W-1:0]     hostWrData,
  output logic      [isc_pkg::DATA_W-1:0]     hostRdData,
  output logic                                hostRdValid,
  input  wire logic [isc_pkg::DATA_W-1:0]     intEnableMask,
  input  wire logic                           softwareRequestTrigger,
  input  wire logic                           stopTxRequest,
  input  wire logic                           txHalted,
  input  wire logic                           rxHalted,
  input  wire logic [31:0]                    dropCount,
  input  wire logic                           txBufferLoaded,
  input  wire logic                           completionNotifyMarker,
  input  wire logic                           rxDmaLoad,
  input  wire logic [isc_pkg::DMA_CNT_W-1:0]  receiveDmaCount,
  input  wire logic                           rxFifoRead,
  input  wire logic [15:0]                    timerCount,
  input  wire logic                           transceiverEventPin,
  input  wire logic                           powerWakeDetect,
  input  wire logic                           txStatusPush,
  input  wire logic                           txStatusFull,
  input  wire logic                           rxPacketEnd,
  input  wire logic [15:0]                    rxPacketLen,
  input  wire logic                           rxErrorEvent,
  input  wire logic                           txErrorEvent,
  input  wire logic                           txDataWrite,
  input  wire logic                           txDataFull,
  input  wire logic [isc_pkg::LEVEL_W-1:0]    txDataFreeBlocks,
  input  wire logic [isc_pkg::LEVEL_W-1:0]    txDataLevel,
  input  wire logic [isc_pkg::LEVEL_W-1:0]    txStatusUsedWords,
  input  wire logic [isc_pkg::LEVEL_W-1:0]    txStatusLevel,
  input  wire logic                           rxStatusFull,
  input  wire logic [isc_pkg::LEVEL_W-1:0]    rxStatusUsedWords,
  input  wire logic [isc_pkg::LEVEL_W-1:0]    rxStatusLevel,
  input  wire logic                           frameDropped,
  input  wire logic [isc_pkg::PIN_COUNT-1:0]  pinEventPins,
  input  wire logic [isc_pkg::PIN_COUNT-1:0]  pinEventEnable,
  input  wire logic [isc_pkg::PIN_COUNT-1:0]  pinEventRising,
  output logic      [isc_pkg::DATA_W-1:0]     interruptEventStatus,
  output logic                                masterIrq,
  output logic                                powerEventIrq,
  output logic                                wakeRequest
);

  import isc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [DATA_W-1:0]    status_r;
  logic [DATA_W-1:0]    status_nxt;
  logic [DATA_W-1:0]    setVec;
  logic [DATA_W-1:0]    clearVec;
  logic [DATA_W-1:0]    rdData_r;
  logic                 rdValid_r;
  logic                 masterIrq_r;
  logic                 powerIrq_r;
  logic                 wake_r;
  logic [31:0]          dropPrev_r;
  logic [15:0]          timerPrev_r;
  logic [DMA_CNT_W-1:0] dmaLeft_r;
  logic                 dmaDone;
  logic                 xcvrLevel;
  logic [PIN_COUNT-1:0] pinRise;
  logic [PIN_COUNT-1:0] pinFall;
  logic                 stsWrite;
  logic                 testWrite;

  // strictly-greater threshold compare
  function automatic logic above(input logic [LEVEL_W-1:0] value,
                                 input logic [LEVEL_W-1:0] level);
    above = value > level;
  endfunction : above

  // host access decode
  function automatic logic hit(input logic               en,
                               input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
    hit = en && (addr == ofs);
  endfunction : hit

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  isc_pin_sync #(.WIDTH(1)) uXcvrSync (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .pinAsync (transceiverEventPin),
    .pinLevel (xcvrLevel),
    .pinRise  (),
    .pinFall  ()
  );

  isc_pin_sync #(.WIDTH(PIN_COUNT)) uPinSync (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .pinAsync (pinEventPins),
    .pinLevel (),
    .pinRise  (pinRise),
    .pinFall  (pinFall)
  );

  // ****************************************************************
  // event history
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dropPrev_r  <= '0;
      timerPrev_r <= TIMER_MAX;
    end
    else
    begin
      dropPrev_r  <= dropCount;
      timerPrev_r <= timerCount;
    end
  end

  // receive dma countdown
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dmaLeft_r <= DMA_CNT_ZERO;
    end
    else if (rxDmaLoad)
    begin
      dmaLeft_r <= receiveDmaCount;
    end
    else if (rxFifoRead && (dmaLeft_r != DMA_CNT_ZERO))
    begin
      dmaLeft_r <= dmaLeft_r - DMA_CNT_ONE;
    end
  end

  assign dmaDone = !rxDmaLoad && rxFifoRead && (dmaLeft_r == DMA_CNT_ONE);

  // ****************************************************************
  // set and clear vectors
  // ****************************************************************
  assign stsWrite  = hit(hostWrEn, hostAddr, OFS_INT_STATUS);
  assign testWrite = hit(hostWrEn, hostAddr, OFS_BYTE_TEST);

  always_comb
  begin
    setVec                  = '0;
    setVec[BIT_SW_REQ]      = softwareRequestTrigger;
    setVec[BIT_TX_HALT]     = stopTxRequest && txHalted;
    setVec[BIT_RX_HALT]     = rxHalted;
    setVec[BIT_DROP_HALF]   = (dropPrev_r == DROP_HALF_PREV) &&
                              (dropCount == DROP_HALF_NEXT);
    setVec[BIT_TX_DONE]     = txBufferLoaded &&
                              completionNotifyMarker;
    setVec[BIT_RX_DMA]      = dmaDone;
    setVec[BIT_TIMER_WRAP]  = (timerPrev_r == TIMER_ZERO) &&
                              (timerCount == TIMER_MAX);
    setVec[BIT_POWER_EVT]   = powerWakeDetect;
    setVec[BIT_TX_STS_OVF]  = txStatusPush && txStatusFull;
    setVec[BIT_RX_WDOG]     = rxPacketEnd &&
                              (rxPacketLen > WDOG_LEN_BYTES);
    setVec[BIT_RX_ERR]      = rxErrorEvent;
    setVec[BIT_TX_ERR]      = txErrorEvent;
    setVec[BIT_TX_OVERRUN]  = txDataWrite && txDataFull;
    setVec[BIT_TX_SPACE]    = above(txDataFreeBlocks, txDataLevel);
    setVec[BIT_TX_STS_FULL] = txStatusFull;
    setVec[BIT_RX_STS_FULL] = rxStatusFull;
    setVec[BIT_TX_STS_LVL]  = above(txStatusUsedWords, txStatusLevel);
    setVec[BIT_RX_STS_LVL]  = above(rxStatusUsedWords, rxStatusLevel);
    setVec[BIT_FRAME_DROP]  = frameDropped;
    setVec[BIT_PIN_LSB +: PIN_COUNT] = pinEventEnable &
      ((pinEventRising & pinRise) | (~pinEventRising & pinFall));
  end

  assign clearVec = stsWrite ? (hostWrData & CLEAR_MASK) : '0;

  always_comb
  begin
    status_nxt = ((status_r & ~clearVec) | setVec) & USED_MASK;
    status_nxt[BIT_XCVR] = xcvrLevel;
  end

  // ****************************************************************
  // status register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_r <= STATUS_RESET;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  // ****************************************************************
  // host read port
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdData_r  <= READ_IDLE;
      rdValid_r <= 1'b0;
    end
    else
    begin
      rdValid_r <= hostRdEn;
      if (hit(hostRdEn, hostAddr, OFS_INT_STATUS))
      begin
        rdData_r <= status_r;
      end
      else
      begin
        rdData_r <= READ_IDLE;
      end
    end
  end

  // ****************************************************************
  // interrupt indications and wake
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      masterIrq_r <= 1'b0;
      powerIrq_r  <= 1'b0;
    end
    else
    begin
      masterIrq_r <= |(status_r & intEnableMask);
      powerIrq_r  <= status_r[BIT_POWER_EVT] &&
                     intEnableMask[BIT_POWER_EVT];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_r <= 1'b0;
    end
    else
    begin
      wake_r <= testWrite;
    end
  end

  assign hostRdData           = rdData_r;
  assign hostRdValid          = rdValid_r;
  assign interruptEventStatus = status_r;
  assign masterIrq            = masterIrq_r;
  assign powerEventIrq        = powerIrq_r;
  assign wakeRequest          = wake_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  AST_CLEAR_ONE: assert property (
    stsWrite && hostWrData[BIT_RX_ERR] && !rxErrorEvent
    |=> !status_r[BIT_RX_ERR])
    else $error("write of one did not clear receive error flag");

  AST_SW_SET: assert property (
    softwareRequestTrigger |=> status_r[BIT_SW_REQ])
    else $error("software trigger did not set its flag");

  AST_TX_HALT: assert property (
    stopTxRequest && txHalted |=> status_r[BIT_TX_HALT])
    else $error("transmit halted flag missing");

  AST_TIMER_WRAP: assert property (
    timerCount == TIMER_ZERO ##1 timerCount == TIMER_MAX
    |=> status_r[BIT_TIMER_WRAP])
    else $error("timer wrap flag missing");

  AST_XCVR_RO: assert property (
    stsWrite |=> status_r[BIT_XCVR] == $past(xcvrLevel))
    else $error("transceiver bit does not follow its source");

  AST_WAKE_SRC: assert property (
    wakeRequest |-> $past(testWrite))
    else $error("wake without a write to byte test");

  AST_PME_NO_WAKE: assert property (
    powerWakeDetect && !testWrite |=> !wakeRequest)
    else $error("power event caused a wake");

  AST_LONG_PKT: assert property (
    rxPacketEnd && rxPacketLen > WDOG_LEN_BYTES
    |=> status_r[BIT_RX_WDOG])
    else $error("long packet flag missing");

  AST_SET_WINS: assert property (
    rxErrorEvent && stsWrite && hostWrData[BIT_RX_ERR]
    |=> status_r[BIT_RX_ERR])
    else $error("event lost against clear");

  AST_STICKY: assert property (
    !stsWrite |=> ((status_r & $past(status_r) & CLEAR_MASK) ==
                   ($past(status_r) & CLEAR_MASK)))
    else $error("flag dropped without a clear");

  AST_RSVD_ZERO: assert property (
    (status_r & ~USED_MASK) == '0)
    else $error("reserved status bit set");

  AST_MASTER: assert property (
    |(status_r & intEnableMask) ##1 1'b1 |-> masterIrq)
    else $error("master indication missing");

  AST_SPACE_GT: assert property (
    txDataFreeBlocks == txDataLevel && !status_r[BIT_TX_SPACE] &&
    !stsWrite |=> !status_r[BIT_TX_SPACE])
    else $error("space flag set at equal level");

  COV_CLEAR: cover property (stsWrite ##1 status_r == '0);
  COV_WAKE: cover property (testWrite ##1 wakeRequest);
  COV_MASTER: cover property (!masterIrq ##1 masterIrq);
  COV_DMA: cover property (rxDmaLoad ##[1:20] status_r[BIT_RX_DMA]);

endmodule : isc_status_collector

//--- hw/isc_pkg.sv
package isc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  OFS_INT_STATUS  = 8'h58;
  localparam logic [7:0]  OFS_BYTE_TEST   = 8'h64;
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE       = 32'h0000_0000;

  // ****************************************************************
  // status bit positions
  // ****************************************************************
  localparam int BIT_SW_REQ      = 31;
  localparam int BIT_TX_HALT     = 25;
  localparam int BIT_RX_HALT     = 24;
  localparam int BIT_DROP_HALF   = 23;
  localparam int BIT_TX_DONE     = 21;
  localparam int BIT_RX_DMA      = 20;
  localparam int BIT_TIMER_WRAP  = 19;
  localparam int BIT_XCVR        = 18;
  localparam int BIT_POWER_EVT   = 17;
  localparam int BIT_TX_STS_OVF  = 16;
  localparam int BIT_RX_WDOG     = 15;
  localparam int BIT_RX_ERR      = 14;
  localparam int BIT_TX_ERR      = 13;
  localparam int BIT_TX_OVERRUN  = 10;
  localparam int BIT_TX_SPACE    = 9;
  localparam int BIT_TX_STS_FULL = 8;
  localparam int BIT_TX_STS_LVL  = 7;
  localparam int BIT_FRAME_DROP  = 6;
  localparam int BIT_RX_STS_FULL = 4;
  localparam int BIT_RX_STS_LVL  = 3;
  localparam int BIT_PIN_LSB     = 0;
  localparam int PIN_COUNT       = 3;

  // implemented bits, and bits that a write of one clears
  localparam logic [31:0] USED_MASK  = 32'h83bf_e7df;
  localparam logic [31:0] CLEAR_MASK = 32'h83bf_e7df & ~32'h0004_0000;

  // ****************************************************************
  // event thresholds
  // ****************************************************************
  localparam logic [15:0] WDOG_LEN_BYTES = 16'd2048;
  localparam logic [31:0] DROP_HALF_PREV = 32'h7fff_ffff;
  localparam logic [31:0] DROP_HALF_NEXT = 32'h8000_0000;
  localparam logic [15:0] TIMER_ZERO     = 16'h0000;
  localparam logic [15:0] TIMER_MAX      = 16'hffff;
  localparam int          LEVEL_W        = 8;
  localparam int          DMA_CNT_W      = 12;
  localparam logic [11:0] DMA_CNT_ONE    = 12'h001;
  localparam logic [11:0] DMA_CNT_ZERO   = 12'h000;

endpackage : isc_pkg

//--- hw/isc_pin_sync.sv
module isc_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinAsync,
  output logic      [WIDTH-1:0] pinLevel,
  output logic      [WIDTH-1:0] pinRise,
  output logic      [WIDTH-1:0] pinFall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  // ****************************************************************
  // two-stage synchroniser and edge history
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= pinAsync;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign pinLevel = sync_r;
  assign pinRise  = sync_r & ~prev_r;
  assign pinFall  = ~sync_r & prev_r;

endmodule : isc_pin_sync

//--- verif/isc_host_model.sv
// ********************
// host cpu register port model
// ********************
module isc_host_model
(
  input  wire logic                       ref_clk,
  input  wire logic [isc_pkg::DATA_W-1:0] hostRdData,
  input  wire logic                       hostRdValid,
  output logic                            hostWrEn,
  output logic                            hostRdEn,
  output logic      [isc_pkg::ADDR_W-1:0] hostAddr,
  output logic      [isc_pkg::DATA_W-1:0] hostWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  import isc_pkg::*;

  initial
  begin
    hostWrEn   = 1'b0;
    hostRdEn   = 1'b0;
    hostAddr   = '0;
    hostWrData = '0;
  end

  // one write, strobe high for one clock; bus inverted when idle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge ref_clk);
    hostAddr   = a;
    hostWrData = d;
    hostWrEn   = 1'b1;
    @(negedge ref_clk);
    hostWrEn   = 1'b0;
    hostAddr   = ~a;
    hostWrData = ~d;
  endtask : wr

  // one read, data taken one clock after the strobe
  task automatic rd(input  logic [ADDR_W-1:0] a,
                    output logic [DATA_W-1:0] d,
                    output logic              v);
    @(negedge ref_clk);
    hostAddr = a;
    hostRdEn = 1'b1;
    @(negedge ref_clk);
    hostRdEn = 1'b0;
    hostAddr = ~a;
    d        = hostRdData;
    v        = hostRdValid;
  endtask : rd
endmodule : isc_host_model

//--- verif/tb.sv
`define CHK(nm, exp, got) \
  begin \
    totalChecks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("FAIL %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import isc_pkg::*;

  // ********************
  // signals
  // ********************
  logic                 ref_clk, resetn;
  logic                 hostWrEn, hostRdEn, hostRdValid, rdValid;
  logic [ADDR_W-1:0]    hostAddr;
  logic [DATA_W-1:0]    hostWrData, hostRdData, interruptEventStatus, rdData;
  logic                 masterIrq, powerEventIrq, wakeRequest;
  logic [DATA_W-1:0]    intEnableMask = '0, dropCount = '0;
  logic                 softwareRequestTrigger = '0, stopTxRequest = '0,
                        txHalted = '0, rxHalted = '0, txBufferLoaded = '0,
                        completionNotifyMarker = '0, rxDmaLoad = '0,
                        rxFifoRead = '0, transceiverEventPin = '0,
                        powerWakeDetect = '0, txStatusPush = '0,
                        txStatusFull = '0, rxPacketEnd = '0,
                        rxErrorEvent = '0, txErrorEvent = '0,
                        txDataWrite = '0, txDataFull = '0,
                        rxStatusFull = '0, frameDropped = '0;
  logic [DMA_CNT_W-1:0] receiveDmaCount = '0;
  logic [15:0]          timerCount = '0, rxPacketLen = '0;
  logic [LEVEL_W-1:0]   txDataFreeBlocks = '0, txDataLevel = '0,
                        txStatusUsedWords = '0, txStatusLevel = '0,
                        rxStatusUsedWords = '0, rxStatusLevel = '0;
  logic [PIN_COUNT-1:0] pinEventPins = '0, pinEventEnable = '0,
                        pinEventRising = '0;
  int                   mismatches = 0, totalChecks = 0;

  isc_status_collector i_dut (
    .ref_clk, .resetn, .hostWrEn, .hostRdEn, .hostAddr, .hostWrData,
    .hostRdData, .hostRdValid, .intEnableMask, .softwareRequestTrigger,
    .stopTxRequest, .txHalted, .rxHalted, .dropCount, .txBufferLoaded,
    .completionNotifyMarker, .rxDmaLoad, .receiveDmaCount, .rxFifoRead,
    .timerCount, .transceiverEventPin, .powerWakeDetect, .txStatusPush,
    .txStatusFull, .rxPacketEnd, .rxPacketLen, .rxErrorEvent,
    .txErrorEvent, .txDataWrite, .txDataFull, .txDataFreeBlocks,
    .txDataLevel, .txStatusUsedWords, .txStatusLevel, .rxStatusFull,
    .rxStatusUsedWords, .rxStatusLevel, .frameDropped, .pinEventPins,
    .pinEventEnable, .pinEventRising, .interruptEventStatus, .masterIrq,
    .powerEventIrq, .wakeRequest);

  isc_host_model i_host (
    .ref_clk, .hostRdData, .hostRdValid, .hostWrEn, .hostRdEn,
    .hostAddr, .hostWrData);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ********************
  // helpers
  // ********************
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic clearAll();
    i_host.wr(OFS_INT_STATUS, 32'hffff_ffff);
  endtask : clearAll

  task automatic setEv(input int b, input logic v);
    case (b)
      BIT_RX_HALT:    rxHalted = v;
      BIT_RX_ERR:     rxErrorEvent = v;
      BIT_TX_ERR:     txErrorEvent = v;
      BIT_FRAME_DROP: frameDropped = v;
      default:        powerWakeDetect = v;
    endcase
  endtask : setEv

  task automatic pulse(input int b);
    @(negedge ref_clk);
    setEv(b, 1'b1);
    @(negedge ref_clk);
    setEv(b, 1'b0);
  endtask : pulse

  task automatic finishTest();
    if (mismatches == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finishTest

  // ********************
  // scenarios
  // ********************
  task automatic testSticky();
    int          bits[5] = '{BIT_RX_HALT, BIT_RX_ERR, BIT_TX_ERR,
                             BIT_FRAME_DROP, BIT_POWER_EVT};
    logic [31:0] one;
    `CHK("reset", STATUS_RESET, interruptEventStatus)
    foreach (bits[i])
    begin
      one = 32'h1 << bits[i];
      pulse(bits[i]);
      tick(3);
      `CHK("held", one, interruptEventStatus)
      i_host.wr(OFS_INT_STATUS, ~one);
      `CHK("zero write", one, interruptEventStatus)
      i_host.wr(OFS_INT_STATUS, one);
      `CHK("one write", 32'h0, interruptEventStatus)
    end
  endtask : testSticky

  task automatic testCompound();
    @(negedge ref_clk);
    rxPacketEnd = 1'b1;
    rxPacketLen = 16'h0800;
    txBufferLoaded = 1'b1;
    txStatusPush = 1'b1;
    txDataWrite = 1'b1;
    @(negedge ref_clk);
    rxPacketLen = 16'h0801;
    completionNotifyMarker = 1'b1;
    txStatusFull = 1'b1;
    txDataFull = 1'b1;
    `CHK("no event", 32'h0, interruptEventStatus)
    @(negedge ref_clk);
    rxPacketEnd = 1'b0;
    txBufferLoaded = 1'b0;
    txStatusPush = 1'b0;
    txDataWrite = 1'b0;
    txStatusFull = 1'b0;
    txDataFull = 1'b0;
    completionNotifyMarker = 1'b0;
    `CHK("events", 32'h0021_8500, interruptEventStatus)
    clearAll();
    `CHK("cleared", 32'h0, interruptEventStatus)
  endtask : testCompound

  task automatic testCounters();
    @(negedge ref_clk);
    dropCount = 32'h7fff_fffe;
    timerCount = 16'h0001;
    rxDmaLoad = 1'b1;
    receiveDmaCount = 12'h002;
    @(negedge ref_clk);
    dropCount = 32'h7fff_ffff;
    timerCount = 16'h0000;
    rxDmaLoad = 1'b0;
    rxFifoRead = 1'b1;
    @(negedge ref_clk);
    rxFifoRead = 1'b0;
    `CHK("no wrap", 32'h0, interruptEventStatus)
    @(negedge ref_clk);
    dropCount = 32'h8000_0000;
    timerCount = 16'hffff;
    rxFifoRead = 1'b1;
    @(negedge ref_clk);
    rxFifoRead = 1'b0;
    dropCount = 32'h8000_0001;
    timerCount = 16'hfffe;
    `CHK("wraps", 32'h0098_0000, interruptEventStatus)
    clearAll();
  endtask : testCounters

  task automatic testLevels();
    @(negedge ref_clk);
    txDataLevel = 8'h05;
    txDataFreeBlocks = 8'h05;
    txStatusLevel = 8'h03;
    txStatusUsedWords = 8'h03;
    rxStatusLevel = 8'h07;
    rxStatusUsedWords = 8'h07;
    stopTxRequest = 1'b1;
    tick(1);
    `CHK("at level", 32'h0, interruptEventStatus)
    txDataFreeBlocks = 8'h06;
    txStatusUsedWords = 8'h04;
    rxStatusUsedWords = 8'h08;
    rxStatusFull = 1'b1;
    softwareRequestTrigger = 1'b1;
    txHalted = 1'b1;
    @(negedge ref_clk);
    txDataFreeBlocks = 8'h05;
    txStatusUsedWords = 8'h03;
    rxStatusUsedWords = 8'h07;
    rxStatusFull = 1'b0;
    softwareRequestTrigger = 1'b0;
    txHalted = 1'b0;
    stopTxRequest = 1'b0;
    `CHK("above", 32'h8200_0298, interruptEventStatus)
    clearAll();
    `CHK("cleared", 32'h0, interruptEventStatus)
  endtask : testLevels

  task automatic testPinsXcvr();
    transceiverEventPin = 1'b1;
    pinEventEnable = 3'b011;
    pinEventRising = 3'b101;
    pinEventPins = 3'b111;
    tick(6);
    `CHK("rise", 32'h0004_0001, interruptEventStatus)
    i_host.wr(OFS_INT_STATUS, 32'h0004_0000);
    `CHK("ro bit", 32'h0004_0001, interruptEventStatus)
    transceiverEventPin = 1'b0;
    pinEventPins = 3'b000;
    tick(6);
    `CHK("fall", 32'h0000_0003, interruptEventStatus)
    clearAll();
    `CHK("cleared", 32'h0, interruptEventStatus)
  endtask : testPinsXcvr

  task automatic testIrq();
    intEnableMask = 32'h0002_4000;
    pulse(BIT_RX_ERR);
    tick(1);
    `CHK("irq on", 1'b1, masterIrq)
    `CHK("pm irq off", 1'b0, powerEventIrq)
    clearAll();
    tick(1);
    `CHK("irq off", 1'b0, masterIrq)
    pulse(BIT_TX_ERR);
    tick(1);
    `CHK("masked", 32'h0000_2000, interruptEventStatus)
    `CHK("masked irq", 1'b0, masterIrq)
    clearAll();
    pulse(BIT_POWER_EVT);
    tick(1);
    `CHK("pm irq", 1'b1, powerEventIrq)
    `CHK("no wake", 1'b0, wakeRequest)
    clearAll();
    intEnableMask = '0;
  endtask : testIrq

  task automatic testHost();
    i_host.wr(OFS_BYTE_TEST, 32'h0);
    `CHK("wake", 1'b1, wakeRequest)
    tick(1);
    `CHK("wake end", 1'b0, wakeRequest)
    pulse(BIT_RX_ERR);
    i_host.rd(OFS_INT_STATUS, rdData, rdValid);
    `CHK("read", 32'h0000_4000, rdData)
    `CHK("valid", 1'b1, rdValid)
    i_host.rd(8'h5c, rdData, rdValid);
    `CHK("other read", READ_IDLE, rdData)
    fork
      i_host.wr(OFS_INT_STATUS, 32'h0000_4000);
      pulse(BIT_RX_ERR);
    join
    `CHK("set wins", 32'h0000_4000, interruptEventStatus)
    clearAll();
    `CHK("cleared", 32'h0, interruptEventStatus)
  endtask : testHost

  // ********************
  // sequence and watchdog
  // ********************
  initial
  begin
    resetn = 1'b0;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    testSticky();
    testCompound();
    testCounters();
    testLevels();
    testPinsXcvr();
    testIrq();
    testHost();
    finishTest();
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    finishTest();
  end
endmodule : tb
